//--- gts_timer_set.sv
// General timer set: one 16-bit timer and a chainable 16/32-bit pair, AXI4-Lite slave
// Summary of operation
// - timer_on starts and stops first timer
// - idle_stop halts timer during Idle
// - Gate accumulates on internal clock only
// - Prescale 1, 8, 64 or 256
// - ext_clock_sync adds sync stage, external only
// - clock_source_sel picks pin edges or cycles
// - Unimplemented bits zero, controls reset zero
// - Unchained pair timers run independently
// - Chained pair is one 32-bit timer
// - Lower word low, upper word high
// - 32-bit period is period_high:period_low
// - Chained mode ignores upper control bits
// - 32-bit match sets upper flag
// - ADC trigger only from chained pair
// - Pair counts exported as time bases
// - pair_32bit_mode selects 32 or 16
// - Match or gate falling edge interrupts
`timescale 1ns/1ns
`default_nettype none
module gts_timer_set
    import gts_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Device state and pins
    input  wire logic        idle_mode,
    input  wire logic        timer1_ext_clock_pin,
    input  wire logic        timer1_gate_pin,
    input  wire logic        lower_ext_clock_pin,
    input  wire logic        lower_gate_pin,
    input  wire logic        upper_ext_clock_pin,
    input  wire logic        upper_gate_pin,
    // Events and time bases
    output logic             timer1_irq_flag,
    output logic             lower_irq_flag,
    output logic             upper_irq_flag,
    output logic             adc_trigger,
    output logic [15:0]      count_low,
    output logic [15:0]      count_high
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0][15:0] ctrl;
        logic [2:0][15:0] cnt;
        logic [2:0][15:0] per;
        logic [2:0][7:0]  psc;
        logic [2:0]       flags;
        logic             adc;
        logic [5:0]       s1;
        logic [5:0]       s2;
        logic [5:0]       s3;
        logic             s4;
        logic             awready;
        logic             wready;
        logic             aw_got;
        logic             w_got;
        logic             bvalid;
        logic [1:0]       bresp;
        logic [7:0]       awaddr;
        logic [31:0]      wdata;
        logic [3:0]       wstrb;
        logic             arready;
        logic             rvalid;
        logic [1:0]       rresp;
        logic [31:0]      rdata;
    } gts_state_t;
    gts_state_t  st;
    gts_state_t  next_st;
    logic [5:0]  rise, fall;
    logic [2:0]  tick, setf;
    logic [15:0] c;
    logic        t32, ext, src, m32, wr_fire;
    function automatic logic [7:0] psc_max(input logic [1:0] sel);
        unique case (sel)
            2'h3: psc_max = PSC_256;
            2'h2: psc_max = PSC_64;
            2'h1: psc_max = PSC_8;
            2'h0: psc_max = PSC_1;
        endcase
    endfunction : psc_max
    function automatic logic [15:0] mrg(input logic [15:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
        mrg = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
    endfunction : mrg
    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        setf    = 3'h0;
        tick    = 3'h0;
        c       = 16'h0000;
        ext     = 1'b0;
        src     = 1'b0;
        next_st.adc = 1'b0;
        // Pins pass two flops before any use
        next_st.s1 = {upper_gate_pin, upper_ext_clock_pin, lower_gate_pin,
                      lower_ext_clock_pin, timer1_gate_pin, timer1_ext_clock_pin};
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.s4 = st.s3[0];
        rise = st.s2 & ~st.s3;
        fall = ~st.s2 & st.s3;
        t32  = st.ctrl[1][B_T32];
        m32  = {st.cnt[2], st.cnt[1]} == {st.per[2], st.per[1]};
        wr_fire = st.aw_got && st.w_got && !st.bvalid;
        // Prescaler and tick per timer; upper is idle when chained
        for (int i = 0; i < NTMR; i++) begin
            c   = st.ctrl[i];
            ext = (i == 0 && c[B_SYNC]) ? (st.s3[0] & ~st.s4) : rise[2*i];
            src = c[B_TCS] ? ext : (!c[B_GATE] || st.s2[2*i+1]);
            if (c[B_ON] && !(idle_mode && c[B_SIDL]) && !(i == 2 && t32)) begin
                if (src) begin
                    if (st.psc[i] >= psc_max(c[B_PSH:B_PSL])) begin
                        next_st.psc[i] = 8'h00;
                        tick[i] = 1'b1;
                    end else begin
                        next_st.psc[i] = st.psc[i] + 8'h01;
                    end
                end
            end
            if (c[B_ON] && !c[B_TCS] && c[B_GATE] && fall[2*i+1] && !(i == 2 && t32)) begin
                if (i == 1 && t32) begin
                    setf[F_HI] = 1'b1;
                end else begin
                    setf[i] = 1'b1;
                end
            end
        end
        // Independent 16-bit counting
        for (int i = 0; i < NTMR; i++) begin
            if (tick[i] && !(t32 && i > 0)) begin
                if (st.cnt[i] == st.per[i]) begin
                    next_st.cnt[i] = 16'h0000;
                    setf[i] = 1'b1;
                end else begin
                    next_st.cnt[i] = st.cnt[i] + 16'h0001;
                end
            end
        end
        // Chained 32-bit counting
        if (t32 && tick[1]) begin
            if (m32) begin
                next_st.cnt[2] = 16'h0000;
                next_st.cnt[1] = 16'h0000;
                setf[F_HI] = 1'b1;
                next_st.adc = 1'b1;
            end else begin
                {next_st.cnt[2], next_st.cnt[1]} = {st.cnt[2], st.cnt[1]} + 32'h1;
            end
        end
        // Write channel: address and data taken in either order
        if (awvalid && st.awready) begin
            next_st.awaddr = awaddr;
            next_st.aw_got = 1'b1;
        end
        if (wvalid && st.wready) begin
            next_st.wdata  = wdata;
            next_st.wstrb  = wstrb;
            next_st.w_got  = 1'b1;
        end
        if (st.bvalid && bready) begin
            next_st.bvalid = 1'b0;
        end
        if (wr_fire) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = RESP_OKAY;
            unique case (st.awaddr)
                OFF_T1_CTRL: begin
                    next_st.ctrl[0] = mrg(st.ctrl[0], st.wdata, st.wstrb) & T1_MASK;
                    next_st.psc[0]  = 8'h00;
                end
                OFF_LO_CTRL: begin
                    next_st.ctrl[1] = mrg(st.ctrl[1], st.wdata, st.wstrb) & LO_MASK;
                    next_st.psc[1]  = 8'h00;
                end
                OFF_HI_CTRL: begin
                    next_st.ctrl[2] = mrg(st.ctrl[2], st.wdata, st.wstrb) & HI_MASK;
                    next_st.psc[2]  = 8'h00;
                end
                OFF_T1_CNT: next_st.cnt[0] = mrg(st.cnt[0], st.wdata, st.wstrb);
                OFF_CNT_LO: next_st.cnt[1] = mrg(st.cnt[1], st.wdata, st.wstrb);
                OFF_CNT_HI: next_st.cnt[2] = mrg(st.cnt[2], st.wdata, st.wstrb);
                OFF_T1_PER: next_st.per[0] = mrg(st.per[0], st.wdata, st.wstrb);
                OFF_PER_LO: next_st.per[1] = mrg(st.per[1], st.wdata, st.wstrb);
                OFF_PER_HI: next_st.per[2] = mrg(st.per[2], st.wdata, st.wstrb);
                OFF_STATUS: begin
                    if (st.wstrb[0]) begin
                        next_st.flags = st.flags & ~st.wdata[2:0];
                    end
                end
                default: next_st.bresp = RESP_SLVERR;
            endcase
        end
        // A new event beats a clear in the same cycle
        next_st.flags   = next_st.flags | setf;
        next_st.awready = !next_st.aw_got && !next_st.bvalid;
        next_st.wready  = !next_st.w_got && !next_st.bvalid;
        // Read channel: data returned one cycle after the address is taken
        if (st.rvalid && rready) begin
            next_st.rvalid = 1'b0;
        end
        if (arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = RESP_OKAY;
            next_st.rdata  = 32'h0;
            unique case (araddr)
                OFF_T1_CTRL: next_st.rdata[15:0] = st.ctrl[0];
                OFF_LO_CTRL: next_st.rdata[15:0] = st.ctrl[1];
                OFF_HI_CTRL: next_st.rdata[15:0] = st.ctrl[2];
                OFF_T1_CNT:  next_st.rdata[15:0] = st.cnt[0];
                OFF_CNT_LO:  next_st.rdata[15:0] = st.cnt[1];
                OFF_CNT_HI:  next_st.rdata[15:0] = st.cnt[2];
                OFF_T1_PER:  next_st.rdata[15:0] = st.per[0];
                OFF_PER_LO:  next_st.rdata[15:0] = st.per[1];
                OFF_PER_HI:  next_st.rdata[15:0] = st.per[2];
                OFF_STATUS:  next_st.rdata[2:0]  = st.flags;
                default:     next_st.rresp = RESP_SLVERR;
            endcase
        end
        next_st.arready = !next_st.rvalid;
    end
    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign awready         = st.awready;
    assign wready          = st.wready;
    assign bvalid          = st.bvalid;
    assign bresp           = st.bresp;
    assign arready         = st.arready;
    assign rvalid          = st.rvalid;
    assign rresp           = st.rresp;
    assign rdata           = st.rdata;
    assign timer1_irq_flag = st.flags[F_T1];
    assign lower_irq_flag  = st.flags[F_LO];
    assign upper_irq_flag  = st.flags[F_HI];
    assign adc_trigger     = st.adc;
    assign count_low       = st.cnt[1];
    assign count_high      = st.cnt[2];
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_t1_off_hold;
        @(posedge aclk) disable iff (!aresetn)
        (!st.ctrl[0][B_ON] && !wr_fire) |=> $stable(st.cnt[0]);
    endproperty
    a_t1_off_hold: assert property (p_t1_off_hold) else $error("timer1 counts while off");
    property p_idle_hold;
        @(posedge aclk) disable iff (!aresetn)
        (st.ctrl[0][B_SIDL] && idle_mode && !wr_fire)
            |=> $stable(st.psc[0]) && $stable(st.cnt[0]);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("timer1 runs in idle");
    property p_gate_hold;
        @(posedge aclk) disable iff (!aresetn)
        (!st.ctrl[0][B_TCS] && st.ctrl[0][B_GATE] && !st.s2[1] && !wr_fire)
            |=> $stable(st.psc[0]) && $stable(st.cnt[0]);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("count with gate low");
    property p_psc_bound;
        @(posedge aclk) disable iff (!aresetn)
        st.psc[0] <= psc_max(st.ctrl[0][B_PSH:B_PSL]);
    endproperty
    a_psc_bound: assert property (p_psc_bound) else $error("prescale overrun");
    property p_ctrl_zero;
        @(posedge aclk) disable iff (!aresetn)
        (st.ctrl[0] & ~T1_MASK) == 16'h0000;
    endproperty
    a_ctrl_zero: assert property (p_ctrl_zero) else $error("unimplemented bit set");
    property p_wrap;
        @(posedge aclk) disable iff (!aresetn)
        (tick[0] && st.cnt[0] == st.per[0] && !wr_fire)
            |=> st.cnt[0] == 16'h0000 && st.flags[F_T1];
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap at match");
    property p_carry;
        @(posedge aclk) disable iff (!aresetn)
        (t32 && tick[1] && !m32 && st.cnt[1] == 16'hFFFF && !wr_fire)
            |=> st.cnt[2] == $past(st.cnt[2]) + 16'h0001;
    endproperty
    a_carry: assert property (p_carry) else $error("no carry into high word");
    property p_match32;
        @(posedge aclk) disable iff (!aresetn)
        (t32 && tick[1] && m32) |=> upper_irq_flag && adc_trigger;
    endproperty
    a_match32: assert property (p_match32) else $error("32-bit match lost");
    property p_adc_src;
        @(posedge aclk) disable iff (!aresetn)
        adc_trigger |-> $past(t32);
    endproperty
    a_adc_src: assert property (p_adc_src) else $error("trigger without chain");
    property p_upper_idle;
        @(posedge aclk) disable iff (!aresetn)
        (t32 && !wr_fire) |=> $stable(st.psc[2]);
    endproperty
    a_upper_idle: assert property (p_upper_idle) else $error("upper prescaler runs in chain");
endmodule : gts_timer_set
`default_nettype wire

//--- gts_pkg.sv
// Constants for the general timer set: register map, control fields, encodings
package gts_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W     = 8;
    localparam logic [7:0] OFF_T1_CTRL = 8'h00;
    localparam logic [7:0] OFF_T1_CNT  = 8'h04;
    localparam logic [7:0] OFF_T1_PER  = 8'h08;
    localparam logic [7:0] OFF_LO_CTRL = 8'h0C;
    localparam logic [7:0] OFF_HI_CTRL = 8'h10;
    localparam logic [7:0] OFF_CNT_LO  = 8'h14;
    localparam logic [7:0] OFF_CNT_HI  = 8'h18;
    localparam logic [7:0] OFF_PER_LO  = 8'h1C;
    localparam logic [7:0] OFF_PER_HI  = 8'h20;
    localparam logic [7:0] OFF_STATUS  = 8'h24;
    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int unsigned B_ON   = 15;
    localparam int unsigned B_SIDL = 13;
    localparam int unsigned B_GATE = 6;
    localparam int unsigned B_PSH  = 5;
    localparam int unsigned B_PSL  = 4;
    localparam int unsigned B_T32  = 3;
    localparam int unsigned B_SYNC = 2;
    localparam int unsigned B_TCS  = 1;
    localparam logic [15:0] T1_MASK   = 16'hA076;
    localparam logic [15:0] LO_MASK   = 16'hA07A;
    localparam logic [15:0] HI_MASK   = 16'hA072;
    localparam logic [15:0] CTRL_RST  = 16'h0000;
    // ------------------------------------------------------------
    // Prescale terminal counts and status bits
    // ------------------------------------------------------------
    localparam logic [7:0] PSC_1   = 8'h00;
    localparam logic [7:0] PSC_8   = 8'h07;
    localparam logic [7:0] PSC_64  = 8'h3F;
    localparam logic [7:0] PSC_256 = 8'hFF;
    localparam int unsigned NTMR   = 3;
    localparam int unsigned F_T1   = 0;
    localparam int unsigned F_LO   = 1;
    localparam int unsigned F_HI   = 2;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : gts_pkg

//--- gts_pin_model.sv
// Pin model: external clock and gate sources for the timer set
`timescale 1ns/1ns
`default_nettype none
module gts_pin_model (
    // External pins, index 0 timer1, 1 lower, 2 upper
    output logic [2:0] ext_clk,
    output logic [2:0] gate
);
    initial begin
        ext_clk = 3'h0;
        gate    = 3'h0;
    end
    // Clock burst of n rising edges; the pin rests low between bursts
    task automatic pulse(input int idx, input int n, input int half_ns);
        repeat (n) begin
            ext_clk[idx] = 1'b1;
            #(half_ns);
            ext_clk[idx] = 1'b0;
            #(half_ns);
        end
    endtask : pulse
    task automatic set_gate(input int idx, input logic lvl);
        gate[idx] = lvl;
    endtask : set_gate
endmodule : gts_pin_model
`default_nettype wire

//--- general_timer_set_tb.sv
// Testbench for the general timer set
`timescale 1ns/1ns
`default_nettype none
module general_timer_set_tb;
    import gts_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, idle_mode;
    logic        awready, wready, bvalid, arready, rvalid, adc_trigger;
    logic        t1_flag, lo_flag, hi_flag;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rsp;
    logic [2:0]  ext_clk, gate;
    logic [15:0] count_low, count_high, rd, v;
    int          err_total, checks_done, n, adc_pulses, a0;
    int          div [4] = '{1, 8, 64, 256};

    gts_pin_model u_gts_pin_model (.ext_clk(ext_clk), .gate(gate));
    gts_timer_set u_gts_timer_set (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .idle_mode(idle_mode),
        .timer1_ext_clock_pin(ext_clk[0]), .timer1_gate_pin(gate[0]),
        .lower_ext_clock_pin(ext_clk[1]), .lower_gate_pin(gate[1]),
        .upper_ext_clock_pin(ext_clk[2]), .upper_gate_pin(gate[2]),
        .timer1_irq_flag(t1_flag), .lower_irq_flag(lo_flag), .upper_irq_flag(hi_flag),
        .adc_trigger(adc_trigger), .count_low(count_low), .count_high(count_high));

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (adc_trigger === 1'b1) begin
            adc_pulses <= adc_pulses + 1;
        end
    end
    // ------------------------------------------------------------
    // Bus and check helpers
    // ------------------------------------------------------------
    task automatic step(input int k);
        repeat (k) @(posedge aclk);
        #1;
    endtask : step
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) begin
                arvalid <= 1'b0;
            end
        end while (rvalid !== 1'b1);
        rd = rdata[15:0];
        rsp = rresp;
        rready <= 1'b0;
    endtask : bus_rd
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string what);
        bus_rd(a);
        chk(what, exp, rd);
    endtask : rd_chk
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd_chk(OFF_T1_CTRL, 16'h0000, "t1_ctrl_reset");
        rd_chk(OFF_LO_CTRL, 16'h0000, "lo_ctrl_reset");
        bus_wr(OFF_T1_CTRL, 16'hFFFF);
        rd_chk(OFF_T1_CTRL, 16'hA076, "t1_ctrl_mask");
        bus_wr(OFF_T1_CTRL, 16'h0000);
        bus_wr(OFF_LO_CTRL, 16'hFFFF);
        rd_chk(OFF_LO_CTRL, 16'hA07A, "lo_ctrl_mask");
        bus_wr(OFF_LO_CTRL, 16'h0000);
        bus_wr(8'h28, 16'h1234);
        chk("bresp_unmapped", {14'h0000, RESP_SLVERR}, {14'h0000, rsp});
        rd_chk(8'h28, 16'h0000, "rdata_unmapped");
        chk("rresp_unmapped", {14'h0000, RESP_SLVERR}, {14'h0000, rsp});
    endtask : t_regs
    task automatic t_t1_int();
        bus_wr(OFF_STATUS, 16'h0007);
        bus_wr(OFF_T1_CNT, 16'h0000);
        bus_wr(OFF_T1_PER, 16'h0003);
        a0 = adc_pulses;
        bus_wr(OFF_T1_CTRL, 16'h8000);
        for (n = 0; n < 20 && t1_flag !== 1'b1; n++) step(1);
        chk("t1_match_flag", 16'h0001, {15'h0000, t1_flag});
        bus_rd(OFF_T1_CNT);
        chk("t1_count_wraps", 16'h0001, {15'h0000, rd <= 16'h0003});
        bus_wr(OFF_T1_CTRL, 16'h0000);
        bus_rd(OFF_T1_CNT);
        v = rd;
        step(10);
        rd_chk(OFF_T1_CNT, v, "t1_stopped");
        chk("adc_from_16bit", 16'(a0), 16'(adc_pulses));
    endtask : t_t1_int
    task automatic t_prescale();
        bus_wr(OFF_PER_LO, 16'hFFFF);
        for (int i = 0; i < 4; i++) begin
            bus_wr(OFF_LO_CTRL, 16'h8000 | (16'(i) << 4));
            step(1);
            v = count_low;
            for (n = 0; n < 300 && count_low === v; n++) step(1);
            step(4 * div[i]);
            chk("prescale_count", v + 16'h0005, count_low);
        end
    endtask : t_prescale
    task automatic t_idle();
        bus_wr(OFF_T1_CTRL, 16'hA000);
        bus_wr(OFF_LO_CTRL, 16'hA000);
        idle_mode <= 1'b1;
        step(2);
        v = count_low;
        step(10);
        chk("idle_halted", v, count_low);
        bus_wr(OFF_LO_CTRL, 16'h8000);
        step(2);
        v = count_low;
        step(10);
        chk("idle_running", v + 16'h000A, count_low);
        idle_mode <= 1'b0;
    endtask : t_idle
    task automatic t_gate();
        bus_wr(OFF_STATUS, 16'h0007);
        bus_wr(OFF_T1_CTRL, 16'h8040);
        bus_wr(OFF_LO_CTRL, 16'h8040);
        bus_wr(OFF_CNT_LO, 16'h0000);
        step(20);
        chk("gate_low_holds", 16'h0000, count_low);
        u_gts_pin_model.set_gate(1, 1'b1);
        step(20);
        chk("gate_high_counts", 16'h0001, {15'h0000, count_low != 16'h0000});
        u_gts_pin_model.set_gate(1, 1'b0);
        step(10);
        chk("gate_fall_flag", 16'h0001, {15'h0000, lo_flag});
        bus_wr(OFF_LO_CTRL, 16'h8042);
        bus_wr(OFF_CNT_LO, 16'h0000);
        u_gts_pin_model.pulse(1, 4, 300);
        step(6);
        chk("ext_ignores_gate", 16'h0004, count_low);
        bus_wr(OFF_LO_CTRL, 16'h0000);
    endtask : t_gate
    task automatic t_t1_ext();
        bus_wr(OFF_T1_PER, 16'hFFFF);
        for (int s = 0; s < 2; s++) begin
            bus_wr(OFF_T1_CTRL, (s == 1) ? 16'h8006 : 16'h8002);
            bus_wr(OFF_T1_CNT, 16'h0000);
            u_gts_pin_model.pulse(0, 5, 300 + 700 * s);
            step(6);
            rd_chk(OFF_T1_CNT, 16'h0005, "t1_ext_count");
        end
        bus_wr(OFF_T1_CTRL, 16'h0000);
    endtask : t_t1_ext
    task automatic t_chain();
        bus_wr(OFF_STATUS, 16'h0007);
        bus_wr(OFF_LO_CTRL, 16'h0008);
        bus_wr(OFF_HI_CTRL, 16'hA030);
        bus_wr(OFF_PER_LO, 16'h0002);
        bus_wr(OFF_PER_HI, 16'h0001);
        bus_wr(OFF_CNT_LO, 16'hFFF0);
        bus_wr(OFF_CNT_HI, 16'h0000);
        bus_wr(OFF_LO_CTRL, 16'h8008);
        for (n = 0; n < 40 && count_high !== 16'h0001; n++) step(1);
        chk("carry_low_word", 16'h0000, count_low);
        for (n = 0; n < 10 && adc_trigger !== 1'b1; n++) step(1);
        chk("adc_on_32bit_match", 16'h0001, {15'h0000, adc_trigger});
        step(1);
        chk("upper_flag", 16'h0001, {15'h0000, hi_flag});
        chk("lower_flag", 16'h0000, {15'h0000, lo_flag});
        chk("wrapped_high", 16'h0000, count_high);
        bus_wr(OFF_LO_CTRL, 16'h0000);
        bus_wr(OFF_HI_CTRL, 16'h0000);
    endtask : t_chain
    task automatic print_verdict();
        if (err_total == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, idle_mode} = 7'h00;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hF;
        {err_total, checks_done, adc_pulses} = 96'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        step(2);
        t_regs();
        t_t1_int();
        t_prescale();
        t_idle();
        t_gate();
        t_t1_ext();
        t_chain();
        print_verdict();
    end
    initial begin
        #(20000 * 100);
        err_total++;
        print_verdict();
    end
endmodule : general_timer_set_tb
`default_nettype wire
